// *** design/pdcp_pkg.sv ***
package pdcp_pkg;
   // output clock indices
   localparam int NUM_OUT = 4;
   localparam int OUT_THIRD = 2;
   localparam int OUT_FOURTH = 3;
   localparam int BUS_AW = 5;
   localparam int BUS_DW = 8;
   // device setting registers
   localparam logic [4:0] REG_DIV_BASE = 5'h00;
   localparam logic [4:0] REG_FBDIV = 5'h04;
   localparam logic [4:0] REG_CTRL = 5'h05;
   localparam logic [4:0] REG_STATUS = 5'h06;
   localparam logic [4:0] REG_FBCNT = 5'h07;
   localparam logic [4:0] REG_PHASE_BASE = 5'h08;
   localparam int CTRL_SRC = 0;
   localparam int CTRL_SEL = 1;
   localparam int CTRL_DIR = 3;
   localparam int CTRL_STEP = 4;
   localparam int ST_LOCK = 0;
   localparam int ST_REFSEL = 1;
   localparam int ST_STANDBY = 2;
   localparam int ST_SRC = 3;
   localparam logic [7:0] DIV_RESET = 8'h03;
   localparam logic [7:0] FBDIV_RESET = 8'h07;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // lock acquisition time, rounded up to core cycles
   localparam int T_LOCK_NS = 4000;
   localparam int CORE_CLK_MHZ = 25;
   localparam int LOCK_CYCLES_DEF = (T_LOCK_NS * CORE_CLK_MHZ + 999) / 1000;
   localparam int BUS_HALF_DEF = 6;
   // device input sync vector positions
   localparam int IN_REF_A = 0;
   localparam int IN_REF_B = 1;
   localparam int IN_BCLK = 2;
   localparam int IN_STB = 3;
   localparam int IN_WE = 4;
   localparam int IN_BRST = 5;
   localparam int IN_STEP = 6;
   localparam int IN_DIR = 7;
   localparam int IN_SEL = 8;
   localparam int IN_STBY = 10;
   localparam int IN_LRST = 11;
   localparam int IN_MRST = 12;
   localparam int IN_CRST = 13;
   localparam int IN_DRST = 14;
   localparam int IN_REFSEL = 15;
   localparam int IN_EN = 16;
   localparam int IN_ADDR = 20;
   localparam int IN_WDATA = 25;
   localparam int IN_W = 33;
   // host registers
   localparam logic [3:0] HREG_ADDR = 4'h0;
   localparam logic [3:0] HREG_WDATA = 4'h1;
   localparam logic [3:0] HREG_CMD = 4'h2;
   localparam logic [3:0] HREG_RDATA = 4'h3;
   localparam logic [3:0] HREG_PHASE = 4'h4;
   localparam logic [3:0] HREG_CTRL = 4'h5;
   localparam logic [3:0] HREG_ENABLE = 4'h6;
   localparam logic [3:0] HREG_STATUS = 4'h7;
   localparam int HS_ACK = 0;
   localparam int HS_LOCK = 1;
   localparam int HS_SRC = 2;
   localparam int HS_RDATA = 3;
   localparam int HS_W = 11;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_WAIT = 2'b10
   } pdcp_bus_state_type;
endpackage

// *** design/pdcp_if.sv ***
interface pdcp_if;
   logic       cfg_bus_clk;
   logic       cfg_bus_reset;
   logic       cfg_bus_strobe;
   logic       cfg_bus_write_en;
   logic [4:0] cfg_bus_addr;
   logic [7:0] cfg_bus_wdata;
   logic [7:0] cfg_bus_rdata;
   logic       cfg_bus_ack;
   logic [1:0] phase_target_select;
   logic       phase_direction;
   logic       phase_step_toggle;
   logic       standby_request;
   logic       loop_reset;
   logic       loop_reset_with_fbdiv;
   logic       third_div_reset;
   logic       fourth_div_reset;
   logic       ref_source_switch;
   logic [3:0] out_enable;
   logic       lock;
   logic       phase_source_flag;
   modport device (
      input  cfg_bus_clk, cfg_bus_reset, cfg_bus_strobe, cfg_bus_write_en,
      input  cfg_bus_addr, cfg_bus_wdata, phase_target_select, phase_direction,
      input  phase_step_toggle, standby_request, loop_reset, loop_reset_with_fbdiv,
      input  third_div_reset, fourth_div_reset, ref_source_switch, out_enable,
      output cfg_bus_rdata, cfg_bus_ack, lock, phase_source_flag
   );
   modport host (
      output cfg_bus_clk, cfg_bus_reset, cfg_bus_strobe, cfg_bus_write_en,
      output cfg_bus_addr, cfg_bus_wdata, phase_target_select, phase_direction,
      output phase_step_toggle, standby_request, loop_reset, loop_reset_with_fbdiv,
      output third_div_reset, fourth_div_reset, ref_source_switch, out_enable,
      input  cfg_bus_rdata, cfg_bus_ack, lock, phase_source_flag
   );
endinterface

// *** design/pdcp_device.sv ***
//  Behaviour
// R01 - phase offset static at reset or dynamic
// R02 - feedback output step drops lock for lock time
// R03 - run-time switch between two reference clocks
// R04 - dividers writable at run time over bus
// R05 - far end provides the bus access block
// R06 - bus setting write drops lock for lock time
// R07 - two-bit select picks the stepped output
// R08 - direction input chooses advance or retard
// R09 - each step toggle moves exactly one step
// R10 - lock high while locked, receiver synchronises
// R11 - flag shows ports or bus phase source
// R12 - standby powers the loop down
// R13 - loop reset keeps feedback divider
// R14 - second reset also clears feedback divider
// R15 - third and fourth divider resets only
// R16 - each output gated by own enable
// R17 - bus reset keeps setting registers
// R18 - bus clock, strobe, write, address, data
// R19 - ack ends each access, strobe held till ack
// R20 - one primary, three secondary shiftable outputs
// R21 - read data valid together with ack
// R22 - far end waits for lock before use
//
// Local design decisions: strobed register access and the address map.
module pdcp_device #(
   parameter int          LOCK_CYCLES  = pdcp_pkg::LOCK_CYCLES_DEF,
   parameter int          FB_OUTPUT    = 0,
   parameter logic [31:0] STATIC_PHASE = 32'h00000000
) (
   // core clock, reset, enable
   input  wire logic I_CORE_CLK,
   input  wire logic I_SRST,
   input  wire logic I_CE,
   // alternative reference clocks
   input  wire logic I_REF_CLK_A,
   input  wire logic I_REF_CLK_B,
   // control and configuration link
   pdcp_if.device    PLL_IF,
   // output clocks
   output wire logic O_PRIMARY_CLK_OUT,
   output wire logic O_SECONDARY_CLK_OUT,
   output wire logic O_THIRD_CLK_OUT,
   output wire logic O_FOURTH_CLK_OUT
);
   import pdcp_pkg::*;

   if (LOCK_CYCLES < 1 || LOCK_CYCLES > 65535 || FB_OUTPUT < 0 || FB_OUTPUT >= NUM_OUT)
   begin : g_bad_param
      $error("pdcp_device: parameter out of range");
   end

   typedef struct packed {
      logic [IN_W-1:0]            in_meta;
      logic [IN_W-1:0]            in_sync;
      logic [IN_W-1:0]            in_prev;
      logic [NUM_OUT-1:0][7:0]    div;
      logic [7:0]                 fbdiv;
      logic [7:0]                 ctrl;
      logic [NUM_OUT-1:0][7:0]    phase_off;
      logic [NUM_OUT-1:0][7:0]    cnt;
      logic [NUM_OUT-1:0]         ph;
      logic [7:0]                 fb_cnt;
      logic [15:0]                lock_cnt;
      logic                       lock;
      logic [NUM_OUT-1:0]         clk_out;
      logic                       ack;
      logic [7:0]                 rdata;
   } pdcp_dev_state_type;

   pdcp_dev_state_type state_reg;
   pdcp_dev_state_type state_next;
   logic [IN_W-1:0]    in_raw;

   // one divider step up or down, wrapping with a half-period toggle
   function automatic logic [8:0] step_fn(input logic p, input logic [7:0] c,
                                          input logic [7:0] d, input logic up);
      logic [8:0] r;
      r = {p, c};
      if (up) begin
         if (c >= d) r = {~p, 8'h00};
         else r = {p, c + 8'h01};
      end else begin
         if (c == 8'h00) r = {~p, d};
         else r = {p, c - 8'h01};
      end
      return r;
   endfunction

   // read decode of the setting map
   function automatic logic [7:0] read_fn(input pdcp_dev_state_type s, input logic [4:0] a);
      logic [7:0] r;
      r = 8'h00;
      if (a < REG_FBDIV) r = s.div[a[1:0]];
      else if (a == REG_FBDIV) r = s.fbdiv;
      else if (a == REG_CTRL) r = {3'h0, 1'b0, s.ctrl[3:0]};
      else if (a == REG_STATUS) begin
         r[ST_LOCK]    = s.lock;
         r[ST_REFSEL]  = s.in_sync[IN_REFSEL];
         r[ST_STANDBY] = s.in_sync[IN_STBY];
         r[ST_SRC]     = s.ctrl[CTRL_SRC];
      end else if (a == REG_FBCNT) r = s.fb_cnt;
      else if (a >= REG_PHASE_BASE && a < REG_PHASE_BASE + 5'h04) r = s.phase_off[a[1:0]];
      return r;
   endfunction

   // every link input is asynchronous to the core clock
   assign in_raw = {PLL_IF.cfg_bus_wdata, PLL_IF.cfg_bus_addr, PLL_IF.out_enable,
                    PLL_IF.ref_source_switch, PLL_IF.fourth_div_reset,
                    PLL_IF.third_div_reset, PLL_IF.loop_reset_with_fbdiv,
                    PLL_IF.loop_reset, PLL_IF.standby_request,
                    PLL_IF.phase_target_select, PLL_IF.phase_direction,
                    PLL_IF.phase_step_toggle, PLL_IF.cfg_bus_reset,
                    PLL_IF.cfg_bus_write_en, PLL_IF.cfg_bus_strobe,
                    PLL_IF.cfg_bus_clk, I_REF_CLK_B, I_REF_CLK_A};

   // next-state logic
   always_comb begin
      logic [IN_W-1:0] sy;
      logic [IN_W-1:0] pv;
      logic            ref_edge;
      logic            bus_edge;
      logic            running;
      logic            disturb;
      logic            step_evt;
      logic [1:0]      step_sel;
      logic            step_dir;
      logic [4:0]      addr;
      logic [7:0]      wd;
      logic [8:0]      r;
      sy = state_reg.in_sync;
      pv = state_reg.in_prev;
      addr = sy[IN_ADDR +: 5];
      wd = sy[IN_WDATA +: 8];
      disturb = 1'b0;
      step_evt = 1'b0;
      step_sel = sy[IN_SEL +: 2];
      step_dir = sy[IN_DIR];
      r = 9'h000;
      state_next = state_reg;
      state_next.in_meta = in_raw;
      state_next.in_sync = state_reg.in_meta;
      state_next.in_prev = sy;
      // ref mux, the reference-select primitive
      ref_edge = sy[IN_REFSEL] ? (sy[IN_REF_B] & ~pv[IN_REF_B])
                               : (sy[IN_REF_A] & ~pv[IN_REF_A]); // R03
      bus_edge = sy[IN_BCLK] & ~pv[IN_BCLK];
      running = ~sy[IN_STBY] & ~sy[IN_LRST] & ~sy[IN_MRST]; // R12
      if (sy[IN_REFSEL] != pv[IN_REFSEL]) disturb = 1'b1; // R03
      // configuration bus: bus reset leaves settings alone
      if (sy[IN_BRST]) begin
         state_next.ack = 1'b0; // R17
         state_next.rdata = 8'h00;
      end else if (bus_edge) begin
         if (sy[IN_STB] && !state_reg.ack) begin
            state_next.ack = 1'b1; // R19
            if (sy[IN_WE]) begin
               if (addr < REG_FBDIV) begin
                  state_next.div[addr[1:0]] = wd; // R04
                  disturb = 1'b1; // R06
               end else if (addr == REG_FBDIV) begin
                  state_next.fbdiv = wd; // R04
                  disturb = 1'b1; // R06
               end else if (addr == REG_CTRL) begin
                  state_next.ctrl = {4'h0, wd[3:0]};
                  if (wd[CTRL_STEP] && wd[CTRL_SRC]) begin
                     step_evt = 1'b1;
                     step_sel = wd[CTRL_SEL +: 2];
                     step_dir = wd[CTRL_DIR];
                  end
               end
            end else begin
               state_next.rdata = read_fn(state_reg, addr); // R21
            end
         end else begin
            state_next.ack = 1'b0; // R19
         end
      end
      // port steps count only while the ports own the phase control
      if (!state_reg.ctrl[CTRL_SRC] && (sy[IN_STEP] != pv[IN_STEP])) begin
         step_evt = 1'b1; // R09
      end
      // output dividers advance on each reference edge while running
      for (int i = 0; i < NUM_OUT; i++) begin
         if (running && ref_edge) begin
            r = step_fn(state_next.ph[i], state_next.cnt[i], state_reg.div[i], 1'b1); // R20
            state_next.ph[i] = r[8];
            state_next.cnt[i] = r[7:0];
         end
         if (running && step_evt && step_sel == i[1:0]) begin
            r = step_fn(state_next.ph[i], state_next.cnt[i], state_reg.div[i], step_dir); // R08
            state_next.ph[i] = r[8]; // R07
            state_next.cnt[i] = r[7:0]; // R09
            state_next.phase_off[i] = step_dir ? state_reg.phase_off[i] + 8'h01
                                               : state_reg.phase_off[i] - 8'h01; // R01
            if (i == FB_OUTPUT) disturb = 1'b1; // R02
         end
      end
      // feedback divider
      if (running && ref_edge) begin
         state_next.fb_cnt = (state_reg.fb_cnt >= state_reg.fbdiv) ? 8'h00
                                                                   : state_reg.fb_cnt + 8'h01;
      end
      // loop resets restart the output dividers at their static phase
      if (sy[IN_LRST] || sy[IN_MRST]) begin
         for (int i = 0; i < NUM_OUT; i++) begin
            state_next.cnt[i] = STATIC_PHASE[i*8 +: 8]; // R13
            state_next.ph[i] = 1'b0;
            state_next.phase_off[i] = STATIC_PHASE[i*8 +: 8];
         end
      end
      if (sy[IN_MRST]) state_next.fb_cnt = 8'h00; // R14
      // these two touch their own divider only
      if (sy[IN_CRST]) begin
         state_next.cnt[OUT_THIRD] = 8'h00; // R15
         state_next.ph[OUT_THIRD] = 1'b0;
      end
      if (sy[IN_DRST]) begin
         state_next.cnt[OUT_FOURTH] = 8'h00; // R15
         state_next.ph[OUT_FOURTH] = 1'b0;
      end
      // lock counter restarts on any disturbance
      if (disturb || !running) begin
         state_next.lock_cnt = 16'h0000; // R02 R06
      end else if (state_reg.lock_cnt < 16'(LOCK_CYCLES)) begin
         state_next.lock_cnt = state_reg.lock_cnt + 16'h0001;
      end
      state_next.lock = (state_next.lock_cnt == 16'(LOCK_CYCLES)); // R10
      // gating from flops keeps the outputs glitch free
      for (int i = 0; i < NUM_OUT; i++) begin
         state_next.clk_out[i] = state_next.ph[i] & sy[IN_EN + i] & ~sy[IN_STBY]; // R16 R12
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         state_reg <= '0;
         for (int i = 0; i < NUM_OUT; i++) begin
            state_reg.div[i] <= DIV_RESET;
            state_reg.cnt[i] <= STATIC_PHASE[i*8 +: 8]; // R01
            state_reg.phase_off[i] <= STATIC_PHASE[i*8 +: 8];
         end
         state_reg.fbdiv <= FBDIV_RESET;
         state_reg.ctrl <= CTRL_RESET;
      end else if (I_CE) begin
         state_reg <= state_next;
      end
   end

   // outputs
   assign PLL_IF.cfg_bus_ack = state_reg.ack; // R19
   assign PLL_IF.cfg_bus_rdata = state_reg.rdata; // R18 R21
   assign PLL_IF.lock = state_reg.lock; // R10
   assign PLL_IF.phase_source_flag = state_reg.ctrl[CTRL_SRC]; // R11
   assign O_PRIMARY_CLK_OUT = state_reg.clk_out[0];
   assign O_SECONDARY_CLK_OUT = state_reg.clk_out[1];
   assign O_THIRD_CLK_OUT = state_reg.clk_out[2];
   assign O_FOURTH_CLK_OUT = state_reg.clk_out[3];

endmodule // pdcp_device

// *** design/pdcp_host.sv ***
module pdcp_host #(
   parameter int BUS_HALF = pdcp_pkg::BUS_HALF_DEF
) (
   // core clock, reset, enable
   input  wire logic       I_CORE_CLK,
   input  wire logic       I_SRST,
   input  wire logic       I_CE,
   // software register port
   input  wire logic [3:0] I_ADDR,
   input  wire logic [7:0] I_WDATA,
   input  wire logic       I_WR,
   input  wire logic       I_RD,
   output wire logic [7:0] O_RDATA,
   // link to the device
   pdcp_if.host            PLL_IF
);
   import pdcp_pkg::*;

   if (BUS_HALF < 5 || BUS_HALF > 255) begin : g_bad_param
      $error("pdcp_host: BUS_HALF out of range");
   end

   typedef struct packed {
      logic [HS_W-1:0]    hs_meta;
      logic [HS_W-1:0]    hs_sync;
      logic [4:0]         addr;
      logic [7:0]         wdata;
      logic               cmd_we;
      logic               pending;
      pdcp_bus_state_type bstate;
      logic               stb;
      logic               we;
      logic [7:0]         bus_rdata;
      logic [1:0]         sel;
      logic               dir;
      logic               step;
      logic [6:0]         ctrl;
      logic [3:0]         en;
      logic [7:0]         div_cnt;
      logic               bclk;
      logic [7:0]         rdata;
   } pdcp_host_state_type;

   pdcp_host_state_type state_reg;
   pdcp_host_state_type state_next;

   // next-state logic
   always_comb begin
      logic busy;
      logic fall;
      busy = state_reg.pending | (state_reg.bstate == BUS_WAIT);
      fall = 1'b0;
      state_next = state_reg;
      // lock and ack arrive asynchronously
      state_next.hs_meta = {PLL_IF.cfg_bus_rdata, PLL_IF.phase_source_flag,
                            PLL_IF.lock, PLL_IF.cfg_bus_ack}; // R10
      state_next.hs_sync = state_reg.hs_meta;
      // read data only in the cycle after the strobe
      state_next.rdata = 8'h00;
      if (I_RD) begin
         unique case (I_ADDR)
            HREG_ADDR:   state_next.rdata = {3'h0, state_reg.addr};
            HREG_WDATA:  state_next.rdata = state_reg.wdata;
            HREG_CMD:    state_next.rdata = {7'h00, busy};
            HREG_RDATA:  state_next.rdata = state_reg.bus_rdata;
            HREG_PHASE:  state_next.rdata = {4'h0, state_reg.step, state_reg.dir, state_reg.sel};
            HREG_CTRL:   state_next.rdata = {1'b0, state_reg.ctrl};
            HREG_ENABLE: state_next.rdata = {4'h0, state_reg.en};
            HREG_STATUS: state_next.rdata = {5'h00, busy, state_reg.hs_sync[HS_SRC],
                                             state_reg.hs_sync[HS_LOCK]}; // R22
            default:     state_next.rdata = 8'h00;
         endcase
      end
      if (I_WR) begin
         unique case (I_ADDR)
            HREG_ADDR:   state_next.addr = I_WDATA[4:0];
            HREG_WDATA:  state_next.wdata = I_WDATA;
            HREG_CMD: begin
               // a command while busy is dropped
               if (!busy && I_WDATA[0]) begin
                  state_next.pending = 1'b1;
                  state_next.cmd_we = I_WDATA[1];
               end
            end
            HREG_PHASE: begin
               state_next.sel = I_WDATA[1:0];
               state_next.dir = I_WDATA[2];
               if (I_WDATA[3]) state_next.step = ~state_reg.step; // R09
            end
            HREG_CTRL:   state_next.ctrl = I_WDATA[6:0];
            HREG_ENABLE: state_next.en = I_WDATA[3:0];
            default: ;
         endcase
      end
      // bus clock divider; strobe and write enable change only at its falling edge or on bus reset
      if (state_reg.div_cnt == 8'(BUS_HALF - 1)) begin
         state_next.div_cnt = 8'h00;
         state_next.bclk = ~state_reg.bclk;
         fall = state_reg.bclk;
      end else begin
         state_next.div_cnt = state_reg.div_cnt + 8'h01;
      end
      if (state_reg.ctrl[6]) begin
         state_next.bstate = BUS_IDLE;
         state_next.stb = 1'b0;
         state_next.pending = 1'b0;
      end else if (fall) begin
         unique case (state_reg.bstate)
            BUS_IDLE: begin
               if (state_reg.pending) begin
                  state_next.stb = 1'b1; // R18
                  state_next.we = state_reg.cmd_we;
                  state_next.pending = 1'b0;
                  state_next.bstate = BUS_WAIT;
               end
            end
            BUS_WAIT: begin
               // strobe stays up until the ack is seen
               if (state_reg.hs_sync[HS_ACK]) begin
                  state_next.stb = 1'b0; // R19
                  state_next.we = 1'b0;
                  if (!state_reg.we) state_next.bus_rdata = state_reg.hs_sync[HS_RDATA +: 8];
                  state_next.bstate = BUS_IDLE;
               end
            end
            default: state_next.bstate = BUS_IDLE;
         endcase
      end
   end

   // state register
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         state_reg <= '0;
         state_reg.bstate <= BUS_IDLE;
         state_reg.en <= 4'hF;
      end else if (I_CE) begin
         state_reg <= state_next;
      end
   end

   // this end plays the bus access block for the device
   assign PLL_IF.cfg_bus_clk = state_reg.bclk; // R05
   assign PLL_IF.cfg_bus_reset = state_reg.ctrl[6];
   assign PLL_IF.cfg_bus_strobe = state_reg.stb;
   assign PLL_IF.cfg_bus_write_en = state_reg.we;
   assign PLL_IF.cfg_bus_addr = state_reg.addr;
   assign PLL_IF.cfg_bus_wdata = state_reg.wdata;
   assign PLL_IF.phase_target_select = state_reg.sel;
   assign PLL_IF.phase_direction = state_reg.dir;
   assign PLL_IF.phase_step_toggle = state_reg.step;
   assign PLL_IF.standby_request = state_reg.ctrl[0];
   assign PLL_IF.loop_reset = state_reg.ctrl[1];
   assign PLL_IF.loop_reset_with_fbdiv = state_reg.ctrl[2];
   assign PLL_IF.third_div_reset = state_reg.ctrl[3];
   assign PLL_IF.fourth_div_reset = state_reg.ctrl[4];
   assign PLL_IF.ref_source_switch = state_reg.ctrl[5];
   assign PLL_IF.out_enable = state_reg.en;
   assign O_RDATA = state_reg.rdata;

endmodule // pdcp_host

// *** bench/pdcp_asserts.sv ***
module pdcp_asserts #(
   parameter int LOCK_CYCLES = pdcp_pkg::LOCK_CYCLES_DEF
) (
   // core domain
   input wire logic       I_CORE_CLK,
   input wire logic       I_SRST,
   // link signals
   input wire logic       cfg_bus_reset,
   input wire logic       cfg_bus_strobe,
   input wire logic       cfg_bus_write_en,
   input wire logic [4:0] cfg_bus_addr,
   input wire logic [7:0] cfg_bus_rdata,
   input wire logic       cfg_bus_ack,
   input wire logic       standby_request,
   input wire logic       loop_reset,
   input wire logic       lock,
   input wire logic       phase_source_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] quiet_reg;
   // quiet cycles, restarted at most one cycle after the loop's own count, so it never falls more than one behind it
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST || standby_request || loop_reset ||
          ($rose(cfg_bus_ack) && cfg_bus_write_en && cfg_bus_addr < 5'h05))
         quiet_reg <= 8'h00;
      else if (quiet_reg != 8'hFF)
         quiet_reg <= quiet_reg + 8'h01;
   end
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SRST || cfg_bus_reset);
   // handshake and settling
   a_ack_on_strobe: assert property ($rose(cfg_bus_ack) |-> cfg_bus_strobe)
      else $error("ack without strobe");
   a_ack_stands: assert property ($rose(cfg_bus_ack) |=> cfg_bus_ack [*8])
      else $error("ack too short");
   a_ack_bounded: assert property ($rose(cfg_bus_strobe) |-> ##[1:20] cfg_bus_ack)
      else $error("ack missing");
   a_req_held: assert property (cfg_bus_strobe && !cfg_bus_ack |=>
      cfg_bus_strobe && $stable(cfg_bus_addr)) else $error("request dropped");
   a_lock_settle: assert property ($rose(lock) |-> quiet_reg >= LOCK_CYCLES - 1)
      else $error("early relock");
   a_standby_unlock: assert property (standby_request [*6] |-> !lock)
      else $error("lock in standby");
   a_src_by_bus: assert property ($changed(phase_source_flag) |-> cfg_bus_ack)
      else $error("source flag moved alone");
   a_bus_rst_idle: assert property (disable iff (I_SRST)
      cfg_bus_reset [*5] |-> !cfg_bus_ack && cfg_bus_rdata == 8'h00)
      else $error("bus reset left ack");
   // main scenarios reached
   c_bus_write: cover property ($rose(cfg_bus_ack) && cfg_bus_write_en);
   c_bus_read: cover property ($rose(cfg_bus_ack) && !cfg_bus_write_en);
   c_relock: cover property ($rose(lock));
endmodule // pdcp_asserts

// *** bench/pll_dynamic_control_port_tb.sv ***
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED %0t got %h want %h", $time, g, e); end end
module pll_dynamic_control_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pdcp_pkg::*;
   localparam logic [31:0] PH0 = 32'h03020100;
   logic       clk = 1'h0, srst = 1'h1, ref_a = 1'h0, ref_b = 1'h0, wr = 1'h0, rd = 1'h0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata, q;
   wire  [3:0] co;
   int         n_mismatch = 0;
   int         tests_run = 0;
   pdcp_if link ();
   // core clock and two unrelated reference clocks
   initial forever #20 clk = ~clk;
   initial forever #160 ref_a = ~ref_a;
   initial #57 forever #160 ref_b = ~ref_b;
   pdcp_device #(.LOCK_CYCLES(60), .STATIC_PHASE(PH0)) u_pdcp_device (.I_CORE_CLK(clk),
      .I_SRST(srst), .I_CE(1'h1), .I_REF_CLK_A(ref_a), .I_REF_CLK_B(ref_b),
      .PLL_IF(link.device), .O_PRIMARY_CLK_OUT(co[0]), .O_SECONDARY_CLK_OUT(co[1]),
      .O_THIRD_CLK_OUT(co[2]), .O_FOURTH_CLK_OUT(co[3]));
   pdcp_host u_pdcp_host (.I_CORE_CLK(clk), .I_SRST(srst), .I_CE(1'h1), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .PLL_IF(link.host));
   pdcp_asserts #(.LOCK_CYCLES(60)) u_pdcp_asserts (.I_CORE_CLK(clk), .I_SRST(srst),
      .cfg_bus_reset(link.cfg_bus_reset), .cfg_bus_strobe(link.cfg_bus_strobe),
      .cfg_bus_write_en(link.cfg_bus_write_en), .cfg_bus_addr(link.cfg_bus_addr),
      .cfg_bus_rdata(link.cfg_bus_rdata), .cfg_bus_ack(link.cfg_bus_ack),
      .standby_request(link.standby_request), .loop_reset(link.loop_reset),
      .lock(link.lock), .phase_source_flag(link.phase_source_flag));
   // host port cycles; one idle edge keeps strobes single-driven
   task automatic hw(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'h1; end
      @(posedge clk) wr <= 1'h0;
   endtask
   task automatic hr(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk) begin addr <= a; rd <= 1'h1; end
      @(posedge clk) rd <= 1'h0;
      @(negedge clk) d = rdata;
   endtask
   // one device access through the host, result always fetched
   task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d,
                      output logic [7:0] r);
      hw(HREG_ADDR, {3'h0, a});
      hw(HREG_WDATA, d);
      hw(HREG_CMD, {6'h00, we, 1'h1});
      r = 8'hFF;
      for (int i = 0; i < 60 && r[2] !== 1'h0; i++) hr(HREG_STATUS, r);
      `CHK(r[2], 1'h0)
      hr(HREG_RDATA, r);
   endtask
   task automatic lock_is(input logic e);
      logic [7:0] s;
      s = {7'h00, ~e};
      for (int i = 0; i < 60 && s[0] !== e; i++) hr(HREG_STATUS, s);
      `CHK(s[0], e)
   endtask
   // outputs that went high at all, after gating settles
   task automatic watch(input logic [3:0] e);
      logic [3:0] seen;
      seen = 4'h0;
      repeat (8) @(negedge clk);
      repeat (200) @(negedge clk) seen = seen | co;
      `CHK(seen, e)
   endtask
   task automatic t_defaults();
      lock_is(1'h1);
      for (int i = 0; i < 6; i++) begin
         bus(1'h0, 5'(i), 8'h00, q);
         `CHK(q, i < 4 ? DIV_RESET : i == 4 ? FBDIV_RESET : CTRL_RESET)
      end
      watch(4'hF);
   endtask
   task automatic t_write();
      bus(1'h1, 5'h01, 8'h05, q);
      lock_is(1'h0);
      bus(1'h0, 5'h01, 8'h00, q);
      `CHK(q, 8'h05)
      bus(1'h1, 5'h1F, 8'hA5, q);
      bus(1'h0, 5'h1F, 8'h00, q);
      `CHK(q, 8'h00)
      lock_is(1'h1);
   endtask
   task automatic t_phase();
      for (int s = 3; s >= 0; s--) begin
         hw(HREG_PHASE, {4'h0, 2'h3, 2'(s)});
         bus(1'h0, REG_PHASE_BASE + 5'(s), 8'h00, q);
         `CHK(q, PH0[8*s +: 8] + 8'h01)
      end
      lock_is(1'h0);
      hw(HREG_PHASE, 8'h0B);
      bus(1'h0, 5'h0B, 8'h00, q);
      `CHK(q, PH0[31:24])
   endtask
   // bus owns stepping: port toggle ignored, bus step counted once
   task automatic t_source();
      bus(1'h1, REG_CTRL, 8'h01, q);
      hr(HREG_STATUS, q);
      `CHK(q[1], 1'h1)
      hw(HREG_PHASE, 8'h0D);
      bus(1'h1, REG_CTRL, 8'h1B, q);
      bus(1'h0, 5'h09, 8'h00, q);
      `CHK(q, PH0[15:8] + 8'h02)
      bus(1'h1, REG_CTRL, 8'h00, q);
   endtask
   task automatic t_gate();
      hw(HREG_ENABLE, 8'h05);
      watch(4'h5);
      hw(HREG_ENABLE, 8'h0F);
      hw(HREG_CTRL, 8'h18);
      watch(4'h3);
      hw(HREG_CTRL, 8'h02);
      lock_is(1'h0);
      hw(HREG_CTRL, 8'h06);
      bus(1'h0, REG_FBCNT, 8'h00, q);
      `CHK(q, 8'h00)
      hw(HREG_CTRL, 8'h01);
      watch(4'h0);
      bus(1'h0, REG_STATUS, 8'h00, q);
      `CHK(q[2], 1'h1)
      hw(HREG_CTRL, 8'h60);
      repeat (8) @(posedge clk);
      hw(HREG_CTRL, 8'h20);
      bus(1'h0, REG_STATUS, 8'h00, q);
      `CHK(q[2:1], 2'h1)
      bus(1'h0, 5'h01, 8'h00, q);
      `CHK(q, 8'h05)
      lock_is(1'h1);
   endtask
   task automatic final_report();
      $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // main sequence after a 16-cycle reset
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'h0;
      t_defaults();
      t_write();
      t_phase();
      t_source();
      t_gate();
      final_report();
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      final_report();
   end
endmodule // pll_dynamic_control_port_tb
